// ===== hw/bcq_pkg.sv
// constants shared by the break channel qualifier match block
package bcq_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam int unsigned BCQ_AW = 8;
  localparam logic [7:0] BCQ_OFS_QUAL_A = 8'h00;
  localparam logic [7:0] BCQ_OFS_ADDR_B = 8'h04;
  localparam logic [7:0] BCQ_OFS_MASK_B = 8'h08;
  localparam logic [7:0] BCQ_OFS_CTRL = 8'h0C;
  localparam logic [7:0] BCQ_OFS_STAT = 8'h10;
  localparam logic [7:0] BCQ_OFS_IMASK = 8'h14;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BCQ_QUAL_W = 8;
  localparam int unsigned BCQ_MST_LO = 6;
  localparam int unsigned BCQ_ACC_LO = 4;
  localparam int unsigned BCQ_DIR_LO = 2;
  localparam int unsigned BCQ_SIZ_LO = 0;
  localparam int unsigned BCQ_CTRL_BUS_SEL = 0;
  localparam int unsigned BCQ_CTRL_ASID_EN = 1;
  localparam int unsigned BCQ_CTRL_ASID_LO = 8;
  localparam int unsigned BCQ_ASID_W = 8;
  localparam int unsigned BCQ_STAT_A = 0;
  localparam int unsigned BCQ_STAT_B = 1;
  localparam int unsigned BCQ_STAT_W = 2;
  // ----------------------------------------
  // field codes
  // ----------------------------------------
  localparam logic [1:0] BCQ_OFF = 2'b00;
  localparam logic [1:0] BCQ_MST_DMA = 2'b10;
  localparam logic [1:0] BCQ_SZ_BYTE = 2'b01;
  localparam logic [1:0] BCQ_SZ_WORD = 2'b10;
  localparam logic [1:0] BCQ_SZ_LONG = 2'b11;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] BCQ_QUAL_RST = 8'h00;
  localparam logic [31:0] BCQ_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] BCQ_MASK_RST = 32'h0000_0000;
  localparam logic [15:0] BCQ_CTRL_RST = 16'h0000;
  localparam logic [1:0] BCQ_STAT_RST = 2'h0;
  localparam logic [31:0] BCQ_ZERO = 32'h0000_0000;
endpackage

// ===== hw/bcq_top.sv
// break channel qualifier match: registers, compare logic, interrupt
`timescale 1ns/1ps
`default_nettype none
module bcq_top
  import bcq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [BCQ_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  input wire logic cyc_valid,
  input wire logic cyc_dma,
  input wire logic cyc_fetch,
  input wire logic cyc_write,
  input wire logic [1:0] cyc_size,
  input wire logic [31:0] cyc_addr_proc,
  input wire logic [31:0] cyc_addr_cache,
  input wire logic [BCQ_ASID_W-1:0] cyc_asid,
  input wire logic chan_a_addr_hit,
  input wire logic chan_b_qual_hit,
  output logic chan_a_match_ff,
  output logic chan_b_match_ff,
  output logic irq_ff
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] qual_a_ff;
  logic [7:0] nxt_qual_a;
  logic [31:0] addr_b_ff;
  logic [31:0] nxt_addr_b;
  logic [31:0] mask_b_ff;
  logic [31:0] nxt_mask_b;
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [BCQ_STAT_W-1:0] imask_ff;
  logic [BCQ_STAT_W-1:0] nxt_imask;
  logic [BCQ_STAT_W-1:0] stat_ff;
  logic [BCQ_STAT_W-1:0] nxt_stat;
  logic [BCQ_STAT_W-1:0] evt;
  logic wr_qual;
  logic wr_stat;
  logic nxt_a_match;
  logic nxt_b_match;
  logic nxt_irq;

  assign wr_qual = reg_wr && (reg_addr == BCQ_OFS_QUAL_A);
  assign wr_stat = reg_wr && (reg_addr == BCQ_OFS_STAT);
  assign evt = {nxt_b_match, nxt_a_match};

  always_comb
  begin
    nxt_qual_a = qual_a_ff;
    nxt_addr_b = addr_b_ff;
    nxt_mask_b = mask_b_ff;
    nxt_ctrl = ctrl_ff;
    nxt_imask = imask_ff;
    // upper bits dropped: reserved bits are not stored
    if (wr_qual)
    begin
      nxt_qual_a = reg_wdata[BCQ_QUAL_W-1:0];
    end
    if (reg_wr && (reg_addr == BCQ_OFS_ADDR_B))
    begin
      nxt_addr_b = reg_wdata;
    end
    if (reg_wr && (reg_addr == BCQ_OFS_MASK_B))
    begin
      nxt_mask_b = reg_wdata;
    end
    if (reg_wr && (reg_addr == BCQ_OFS_CTRL))
    begin
      nxt_ctrl = reg_wdata[15:0];
    end
    if (reg_wr && (reg_addr == BCQ_OFS_IMASK))
    begin
      nxt_imask = reg_wdata[BCQ_STAT_W-1:0];
    end
    // set wins over a write-one clear
    nxt_stat = stat_ff & ~(wr_stat ? reg_wdata[BCQ_STAT_W-1:0] : BCQ_STAT_RST);
    nxt_stat = nxt_stat | evt;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      qual_a_ff <= BCQ_QUAL_RST;
      addr_b_ff <= BCQ_ADDR_RST;
      mask_b_ff <= BCQ_MASK_RST;
      ctrl_ff <= BCQ_CTRL_RST;
      imask_ff <= BCQ_STAT_RST;
      stat_ff <= BCQ_STAT_RST;
    end
    else
    begin
      qual_a_ff <= nxt_qual_a;
      addr_b_ff <= nxt_addr_b;
      mask_b_ff <= nxt_mask_b;
      ctrl_ff <= nxt_ctrl;
      imask_ff <= nxt_imask;
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [31:0] nxt_rdata;

  always_comb
  begin
    nxt_rdata = BCQ_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        BCQ_OFS_QUAL_A: nxt_rdata = {24'h00_0000, qual_a_ff};
        BCQ_OFS_ADDR_B: nxt_rdata = addr_b_ff;
        BCQ_OFS_MASK_B: nxt_rdata = mask_b_ff;
        BCQ_OFS_CTRL: nxt_rdata = {16'h0000, ctrl_ff};
        BCQ_OFS_STAT: nxt_rdata = {30'h0000_0000, stat_ff};
        BCQ_OFS_IMASK: nxt_rdata = {30'h0000_0000, imask_ff};
        // unmapped reads return zero
        default: nxt_rdata = BCQ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_ff <= BCQ_ZERO;
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // channel A qualifiers
  // ----------------------------------------
  logic [1:0] mst;
  logic [1:0] acc;
  logic [1:0] dir;
  logic [1:0] siz;
  logic mst_ok;
  logic acc_ok;
  logic dir_ok;
  logic siz_ok;
  logic qual_a_hit;

  assign mst = qual_a_ff[BCQ_MST_LO+:2];
  assign acc = qual_a_ff[BCQ_ACC_LO+:2];
  assign dir = qual_a_ff[BCQ_DIR_LO+:2];
  assign siz = qual_a_ff[BCQ_SIZ_LO+:2];

  always_comb
  begin
    mst_ok = (mst == BCQ_OFF) || (mst[0] && !cyc_dma) || ((mst == BCQ_MST_DMA) && cyc_dma);
    acc_ok = (acc == BCQ_OFF) || (acc[0] && cyc_fetch) || (acc[1] && !cyc_fetch);
    dir_ok = (dir == BCQ_OFF) || (dir[0] && !cyc_write) || (dir[1] && cyc_write);
    siz_ok = (siz == BCQ_OFF) || (siz == cyc_size);
    qual_a_hit = mst_ok && acc_ok && dir_ok && siz_ok;
  end

  // ----------------------------------------
  // channel B address compare
  // ----------------------------------------
  logic [31:0] sel_addr;
  logic [31:0] bit_ok;
  logic asid_ok;
  logic addr_b_hit;

  assign sel_addr = ctrl_ff[BCQ_CTRL_BUS_SEL] ? cyc_addr_cache : cyc_addr_proc;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_bit
      assign bit_ok[gi] = mask_b_ff[gi] || (sel_addr[gi] == addr_b_ff[gi]);
    end
  endgenerate

  always_comb
  begin
    asid_ok = !ctrl_ff[BCQ_CTRL_ASID_EN] || (cyc_asid == ctrl_ff[BCQ_CTRL_ASID_LO+:BCQ_ASID_W]);
    addr_b_hit = (&bit_ok) && asid_ok;
  end

  // ----------------------------------------
  // match outputs and interrupt
  // ----------------------------------------
  always_comb
  begin
    nxt_a_match = cyc_valid && chan_a_addr_hit && qual_a_hit;
    nxt_b_match = cyc_valid && addr_b_hit && chan_b_qual_hit;
    // irq follows the status one cycle late, as it is registered
    nxt_irq = |(stat_ff & imask_ff);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      chan_a_match_ff <= 1'b0;
      chan_b_match_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      chan_a_match_ff <= nxt_a_match;
      chan_b_match_ff <= nxt_b_match;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_qual_wr;
    reg_wr && (reg_addr == BCQ_OFS_QUAL_A);
  endsequence

  sequence s_qual_rd;
    reg_rd && (reg_addr == BCQ_OFS_QUAL_A);
  endsequence

  property p_qual_rt;
    @(posedge ref_clk) disable iff (rst)
      s_qual_wr ##1 s_qual_rd |=> reg_rdata_ff[7:0] == $past(reg_wdata[7:0], 2);
  endproperty
  a_qual_rt: assert property (p_qual_rt) else $error("qualifier readback wrong");

  property p_resv_zero;
    @(posedge ref_clk) disable iff (rst)
      s_qual_rd |=> reg_rdata_ff[31:8] == 24'h00_0000;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

  property p_mst;
    @(posedge ref_clk) disable iff (rst)
      (mst == BCQ_MST_DMA) && !cyc_dma |=> !chan_a_match_ff;
  endproperty
  a_mst: assert property (p_mst) else $error("dma select matched cpu cycle");

  property p_acc;
    @(posedge ref_clk) disable iff (rst)
      cyc_valid && chan_a_addr_hit && (acc == 2'b01) && !cyc_fetch |=> !chan_a_match_ff;
  endproperty
  a_acc: assert property (p_acc) else $error("fetch select matched data");

  property p_dir;
    @(posedge ref_clk) disable iff (rst)
      cyc_valid && (dir == 2'b10) && !cyc_write |=> !chan_a_match_ff;
  endproperty
  a_dir: assert property (p_dir) else $error("write select matched read");

  property p_all_off;
    @(posedge ref_clk) disable iff (rst)
      cyc_valid && chan_a_addr_hit && (qual_a_ff == BCQ_QUAL_RST) |=> chan_a_match_ff;
  endproperty
  a_all_off: assert property (p_all_off) else $error("open qualifiers missed a match");

  property p_siz;
    @(posedge ref_clk) disable iff (rst)
      chan_a_match_ff && ($past(siz) != BCQ_OFF) |-> $past(cyc_size) == $past(siz);
  endproperty
  a_siz: assert property (p_siz) else $error("size mismatch matched");

  property p_addr_wr;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && (reg_addr == BCQ_OFS_ADDR_B) ##1 reg_rd && (reg_addr == BCQ_OFS_ADDR_B)
        |=> reg_rdata_ff == $past(reg_wdata, 2);
  endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("address readback wrong");

  property p_mask_wr;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && (reg_addr == BCQ_OFS_MASK_B) |=> mask_b_ff == $past(reg_wdata);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not stored");

  property p_b_cmp;
    @(posedge ref_clk) disable iff (rst)
      chan_b_match_ff |-> (($past(sel_addr) ^ $past(addr_b_ff)) & ~$past(mask_b_ff)) == BCQ_ZERO;
  endproperty
  a_b_cmp: assert property (p_b_cmp) else $error("unmasked bit differed on match");

  property p_bus_sel;
    @(posedge ref_clk) disable iff (rst)
      chan_b_match_ff && $past(ctrl_ff[BCQ_CTRL_BUS_SEL]) && ($past(mask_b_ff) == BCQ_ZERO)
        |-> $past(cyc_addr_cache) == $past(addr_b_ff);
  endproperty
  a_bus_sel: assert property (p_bus_sel) else $error("wrong bus compared");

  property p_a_cause;
    @(posedge ref_clk) disable iff (rst)
      chan_a_match_ff |-> $past(cyc_valid) && $past(chan_a_addr_hit);
  endproperty
  a_a_cause: assert property (p_a_cause) else $error("match without cause");

  property p_irq;
    @(posedge ref_clk) disable iff (rst)
      chan_b_match_ff && imask_ff[BCQ_STAT_B] |=> irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule // bcq_top
`default_nettype wire

// ===== tb/bcq_bus_model.sv
// bus cycle source standing in for processor and dma traffic
`timescale 1ns/1ps
`default_nettype none
module bcq_bus_model
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [4:0] attr,
  input wire logic [31:0] ap,
  input wire logic [31:0] ac,
  output logic cyc_valid,
  output logic cyc_dma,
  output logic cyc_fetch,
  output logic cyc_write,
  output logic [1:0] cyc_size,
  output logic [31:0] cyc_addr_proc,
  output logic [31:0] cyc_addr_cache
);
  logic [68:0] drv;
  logic [68:0] flip_ff = '0;
  assign drv = go ? {attr, ap, ac} : flip_ff;
  // idle lines toggle so no stale value passes for a real cycle
  always @(posedge ref_clk)
    flip_ff <= ~drv;
  assign {cyc_dma, cyc_fetch, cyc_write, cyc_size, cyc_addr_proc, cyc_addr_cache} = drv;
  assign cyc_valid = go;
endmodule // bcq_bus_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the break channel qualifier match block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bcq_pkg::*;
;
  logic ref_clk, rst, reg_wr, reg_rd, go, a_hit, b_hit, b_sel, rd_seen, cy_seen;
  logic cyc_valid, cyc_dma, cyc_fetch, cyc_write, chan_a_match_ff, chan_b_match_ff, irq_ff;
  logic [BCQ_AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, ap, ac, b_addr, b_mask, x, cyc_addr_proc, cyc_addr_cache;
  logic [4:0] attr;
  logic [1:0] cyc_size, sticky;
  logic [7:0] qual, asid, b_asid;
  logic b_asen;
  logic [31:0] q_r[$];
  logic [1:0] q_m[$];
  int err_count, samples_checked, cycles;

  bcq_bus_model bus (.ref_clk(ref_clk), .go(go), .attr(attr), .ap(ap), .ac(ac), .cyc_valid(cyc_valid),
    .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch), .cyc_write(cyc_write), .cyc_size(cyc_size),
    .cyc_addr_proc(cyc_addr_proc), .cyc_addr_cache(cyc_addr_cache));
  bcq_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .cyc_valid(cyc_valid), .cyc_dma(cyc_dma),
    .cyc_fetch(cyc_fetch), .cyc_write(cyc_write), .cyc_size(cyc_size), .cyc_addr_proc(cyc_addr_proc),
    .cyc_addr_cache(cyc_addr_cache), .cyc_asid(asid), .chan_a_addr_hit(a_hit), .chan_b_qual_hit(b_hit),
    .chan_a_match_ff(chan_a_match_ff), .chan_b_match_ff(chan_b_match_ff), .irq_ff(irq_ff));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_match(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t match or irq %b expected %b", $time, got, exp);
    end
  endtask

  // one bus step: every strobe assigned once per edge
  task automatic drv(input logic w, input logic r, input logic g, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    go <= g;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drv(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_r.push_back(e);
    drv(1'b0, 1'b1, 1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic qual_ok(input logic [7:0] q, input logic [4:0] t);
    logic m, a, d, s;
    m = (q[7:6] == 2'b00) || (q[6] ? !t[4] : t[4]);
    a = (q[5:4] == 2'b00) || (q[5:4] == 2'b11) || (q[4] ? t[3] : !t[3]);
    d = (q[3:2] == 2'b00) || (q[3:2] == 2'b11) || (q[2] ? !t[2] : t[2]);
    s = (q[1:0] == 2'b00) || (q[1:0] == t[1:0]);
    return m && a && d && s;
  endfunction

  task automatic cyc(input logic [31:0] p, input logic [31:0] c);
    logic [4:0] t;
    logic ha, hb, ea, eb;
    logic [7:0] av;
    t = 5'($urandom);
    if (t[1:0] == 2'b00)
      t[1:0] = 2'b11;
    ha = 1'($urandom);
    hb = 1'($urandom);
    av = b_asid ^ 8'($urandom % 2);
    ea = ha && qual_ok(qual, t);
    eb = hb && (!b_asen || (av == b_asid)) && ((((b_sel ? c : p) ^ b_addr) & ~b_mask) == 32'h0000_0000);
    sticky = sticky | {eb, ea};
    q_m.push_back({eb, ea});
    attr <= t;
    ap <= p;
    ac <= c;
    a_hit <= ha;
    b_hit <= hb;
    asid <= av;
    drv(1'b0, 1'b0, 1'b1, 8'h00, 32'h0000_0000);
  endtask

  // results land one edge after the request
  always @(posedge ref_clk)
  begin
    rd_seen <= reg_rd;
    cy_seen <= go;
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      finish_test();
    end
  end

  always @(negedge ref_clk)
  begin
    if (rd_seen === 1'b1)
      cmp_reg(reg_rdata_ff, q_r.pop_front()); // read value
    if (cy_seen === 1'b1)
      cmp_match({chan_b_match_ff, chan_a_match_ff}, q_m.pop_front()); // match pair
  end

  initial
  begin
    {rst, reg_wr, reg_rd, go, a_hit, b_hit, b_sel, rd_seen, cy_seen} = 9'h100;
    {reg_addr, reg_wdata, ap, ac, attr, qual, sticky} = '0;
    {b_addr, b_mask, asid, b_asid, b_asen} = '0;
    void'($urandom(32'h925af465));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(BCQ_OFS_QUAL_A, BCQ_ZERO); // reset value
    rd(BCQ_OFS_ADDR_B, BCQ_ZERO); // reset value
    rd(BCQ_OFS_MASK_B, BCQ_ZERO); // reset value
    wr(BCQ_OFS_QUAL_A, 32'h0000_00FF); // reserved byte written as zero
    rd(BCQ_OFS_QUAL_A, 32'h0000_00FF); // upper byte reads zero
    b_addr = $urandom;
    wr(BCQ_OFS_ADDR_B, b_addr);
    rd(BCQ_OFS_ADDR_B, b_addr); // read back
    rd(8'h1C, BCQ_ZERO);
    // every qualifier code against random cycles
    for (int q = 0; q < 256; q++)
    begin
      qual = 8'(q);
      wr(BCQ_OFS_QUAL_A, {24'h00_0000, qual}); // upper byte kept zero
      repeat (3) cyc($urandom, $urandom);
    end
    for (int i = 0; i < 200; i++)
    begin
      if (i % 50 == 0)
      begin
        // zero mask on the cache bus at 150 so exact hits on that bus occur
        b_sel = (i == 150) ? 1'b1 : 1'($urandom);
        b_mask = (i == 100) ? 32'hFFFF_FFFF : ((i == 150) ? 32'h0000_0000 : ($urandom & $urandom));
        // asid prefix compared only in the second block
        b_asen = (i == 50);
        b_asid = 8'($urandom);
        wr(BCQ_OFS_CTRL, {16'h0000, b_asid, 6'h00, b_asen, b_sel}); // bus and asid select
        wr(BCQ_OFS_MASK_B, b_mask);
        rd(BCQ_OFS_MASK_B, b_mask); // read back
      end
      x = b_addr ^ ($urandom & b_mask) ^ (($urandom % 2) ? (32'h0000_0001 << ($urandom % 32)) : 32'h0000_0000);
      cyc(b_sel ? ~x : x, b_sel ? x : ~x);
    end
    // sticky status, mask, write-one clear
    rd(BCQ_OFS_STAT, {30'h0000_0000, sticky});
    wr(BCQ_OFS_IMASK, 32'h0000_0003);
    // matches while unmasked, so the interrupt path sees live events
    repeat (8) cyc($urandom, b_addr);
    repeat (2) drv(1'b0, 1'b0, 1'b0, 8'h00, 32'h0000_0000);
    @(negedge ref_clk) cmp_match({1'b0, irq_ff}, {1'b0, |sticky});
    @(posedge ref_clk);
    wr(BCQ_OFS_STAT, 32'h0000_0003);
    repeat (2) drv(1'b0, 1'b0, 1'b0, 8'h00, 32'h0000_0000);
    @(negedge ref_clk) cmp_match({1'b0, irq_ff}, 2'b00);
    @(posedge ref_clk);
    rd(BCQ_OFS_STAT, BCQ_ZERO);
    repeat (2) drv(1'b0, 1'b0, 1'b0, 8'h00, 32'h0000_0000);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
